// ### rtl/wss_pkg.sv
package wss_pkg;
   // ======================================================
   // schedule select modes
   localparam logic [1:0] WSS_MODE_INTERNAL = 2'h0;
   localparam logic [1:0] WSS_MODE_EXTERNAL = 2'h1;
   localparam logic [1:0] WSS_MODE_TWOHAND  = 2'h2;
   localparam logic [1:0] WSS_MODE_BINARY   = 2'h3;
   localparam logic [1:0] WSS_MODE_RESET    = WSS_MODE_INTERNAL;
   // ======================================================
   // schedule numbers
   localparam logic [5:0] WSS_SCHED_00  = 6'h00;
   localparam logic [5:0] WSS_SCHED_10  = 6'h0A;
   localparam logic [5:0] WSS_SCHED_20  = 6'h14;
   localparam logic [5:0] WSS_SCHED_30  = 6'h1E;
   localparam logic [5:0] WSS_SCHED_MAX = 6'h31;
   localparam logic [5:0] WSS_SCHED_CNT = 6'h32;
   // ======================================================
   // seam settings
   localparam logic [7:0] WSS_SEAM_SPOT    = 8'h00;
   localparam logic [7:0] WSS_SEAM_NONBEAT = 8'h06;
   localparam logic [3:0] WSS_SEAM_DLYCOMP = 4'h4;
   // ======================================================
   // timing
   localparam int WSS_CLK_MHZ      = 100;
   localparam int WSS_WINDOW_MS    = 500;
   localparam int WSS_WINDOW_CYC   = WSS_WINDOW_MS * 1000 * WSS_CLK_MHZ;
   localparam logic [1:0] WSS_BOARD_SETTLE = 2'h2;
   // ======================================================
   // carriers
   typedef struct packed {
      logic primary;
      logic second;
      logic third;
   } wss_init_t;
   typedef struct packed {
      logic       start;
      logic [5:0] sched;
      logic       twoHand;
      logic       chainAllowed;
      logic       nonBeat;
   } wss_start_t;
endpackage

// ### rtl/wss_weld_schedule_select.sv
// Summary of operation
// - setting 00 internal, 01 external, 02 two-hand, 03 binary select
// - reset leaves the setting at internal panel-dialed mode
// - internal: primary input starts on the panel schedule
// - internal: second input always starts schedule 10
// - internal: third input always starts schedule 20
// - external: second/third pick 00,10,20,30; primary starts it
// - external: panel ignored, only primary input initiates
// - change to internal mode clears schedules 10 and 20
// - two-hand: both inputs must close within 0.5 s
// - missed window shows error until all closed inputs release
// - two-hand: release before squeeze end retracts electrodes
// - chained two-hand: hold until last new-valve squeeze ends
// - board found after reset enables binary select in two-hand mode
// - setting 03 accepted only with the binary board present
// - binary: six bits choose schedule, primary starts, panel ignored
// - binary: second and third inputs still start 10 and 20
// - seam 06 runs non-beat weld alternating two heats, repeated
// - normal seam mode forbids chaining of schedules
// - binary value 50 or more is shown and used as 49
`timescale 1ns/1ns
module wss_weld_schedule_select
   import wss_pkg::*;
#(
   parameter int WINDOW_CYC = WSS_WINDOW_CYC
)(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire wss_init_t  initPins,
   input  wire logic [5:0] binarySelectPins,
   input  wire logic       binarySelectOptionBoard,
   input  wire logic [1:0] modeSetting,
   input  wire logic       modeWrite,
   input  wire logic [5:0] panelSchedule,
   input  wire logic [7:0] seamSetting,
   input  wire logic       sequenceBusy,
   input  wire logic       squeezeActive,
   output logic [1:0]      scheduleSelectMode,
   output wss_start_t      startCmd,
   output logic            clearSchedules,
   output logic            twoHandError,
   output logic            retractElectrodes,
   output logic [5:0]      displaySchedule
);
   // ======================================================
   // input synchronisers
   wss_init_t  initMeta_reg, initSync_reg;
   logic [5:0] binMeta_reg, binSync_reg;
   logic       brdMeta_reg, brdSync_reg;
   wss_init_t  initPrev_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         initMeta_reg <= '0;
         initSync_reg <= '0;
         initPrev_reg <= '0;
         binMeta_reg  <= 6'h00;
         binSync_reg  <= 6'h00;
         brdMeta_reg  <= 1'b0;
         brdSync_reg  <= 1'b0;
      end else begin
         initMeta_reg <= initPins;
         initSync_reg <= initMeta_reg;
         initPrev_reg <= initSync_reg;
         binMeta_reg  <= binarySelectPins;
         binSync_reg  <= binMeta_reg;
         brdMeta_reg  <= binarySelectOptionBoard;
         brdSync_reg  <= brdMeta_reg;
      end
   end

   function automatic logic [5:0] clampSched(input logic [5:0] v);
      clampSched = (v >= WSS_SCHED_CNT) ? WSS_SCHED_MAX : v;
   endfunction

   // ======================================================
   // mode setting and board detect
   logic [1:0] mode_reg, mode_next;
   logic       boardSeen_reg, boardSeen_next;
   logic       boardDone_reg, boardDone_next;
   logic [1:0] boardAge_reg, boardAge_next;
   logic       clear_reg, clear_next;

   always_comb begin
      mode_next      = mode_reg;
      clear_next     = 1'b0;
      boardAge_next  = boardAge_reg;
      boardDone_next = boardDone_reg;
      boardSeen_next = boardSeen_reg;
      // wait for the board synchroniser to refill after reset
      if (boardAge_reg != WSS_BOARD_SETTLE) begin
         boardAge_next = boardAge_reg + 2'h1;
      end else if (!boardDone_reg) begin
         boardDone_next = 1'b1;
         boardSeen_next = brdSync_reg;
      end
      if (modeWrite) begin
         if (modeSetting == WSS_MODE_BINARY) begin
            if (boardSeen_reg) begin
               mode_next = modeSetting;
            end
         end else begin
            mode_next = modeSetting;
         end
         if (modeSetting == WSS_MODE_INTERNAL && mode_reg != WSS_MODE_INTERNAL) begin
            clear_next = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_reg      <= WSS_MODE_RESET;
         boardSeen_reg <= 1'b0;
         boardDone_reg <= 1'b0;
         boardAge_reg  <= 2'h0;
         clear_reg     <= 1'b0;
      end else begin
         mode_reg      <= mode_next;
         boardSeen_reg <= boardSeen_next;
         boardDone_reg <= boardDone_next;
         boardAge_reg  <= boardAge_next;
         clear_reg     <= clear_next;
      end
   end

   // ======================================================
   // two-hand state machine
   typedef enum logic [3:0] {
      TH_IDLE  = 4'b0001,
      TH_WAIT  = 4'b0010,
      TH_RUN   = 4'b0100,
      TH_ERROR = 4'b1000
   } wss_th_t;

   wss_th_t     th_reg, th_next;
   logic [31:0] win_reg, win_next;
   logic        retract_reg, retract_next;
   logic        thStart;
   logic        bothHands, anyHand, anyInit;

   assign bothHands = initSync_reg.second & initSync_reg.third;
   assign anyHand   = initSync_reg.second | initSync_reg.third;
   assign anyInit   = anyHand | initSync_reg.primary;

   always_comb begin
      th_next      = th_reg;
      win_next     = win_reg;
      retract_next = 1'b0;
      thStart      = 1'b0;
      case (th_reg)
         TH_IDLE: begin
            win_next = 32'h0;
            if (mode_reg == WSS_MODE_TWOHAND && !sequenceBusy) begin
               if (bothHands) begin
                  th_next = TH_RUN;
                  thStart = 1'b1;
               end else if (anyHand) begin
                  th_next = TH_WAIT;
               end
            end
         end
         TH_WAIT: begin
            win_next = win_reg + 32'h1;
            if (bothHands) begin
               th_next = TH_RUN;
               thStart = 1'b1;
            end else if (!anyHand) begin
               th_next = TH_IDLE;
            end else if (win_reg >= 32'(WINDOW_CYC - 1)) begin
               th_next = TH_ERROR;
            end
         end
         TH_RUN: begin
            if (squeezeActive && !bothHands && mode_reg == WSS_MODE_TWOHAND) begin
               retract_next = 1'b1;
               th_next      = TH_ERROR;
            end else if (!sequenceBusy && !anyHand) begin
               th_next = TH_IDLE;
            end
         end
         TH_ERROR: begin
            if (!anyInit) begin
               th_next = TH_IDLE;
            end
         end
         default: th_next = TH_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         th_reg      <= TH_IDLE;
         win_reg     <= 32'h0;
         retract_reg <= 1'b0;
      end else begin
         th_reg      <= th_next;
         win_reg     <= win_next;
         retract_reg <= retract_next;
      end
   end

   // ======================================================
   // initiation decode
   wss_start_t start_reg, start_next;
   logic [5:0] disp_reg, disp_next;
   logic       rise1, rise2, rise3;
   logic       errLatched_reg, errLatched_next;
   logic [5:0] binSched, extSched, panelOrBin;
   logic       seamNormal;

   assign rise1      = initSync_reg.primary & ~initPrev_reg.primary;
   assign rise2      = initSync_reg.second & ~initPrev_reg.second;
   assign rise3      = initSync_reg.third & ~initPrev_reg.third;
   assign binSched   = clampSched(binSync_reg);
   assign extSched   = {initSync_reg.third, initSync_reg.second} == 2'b11 ? WSS_SCHED_30 :
                       initSync_reg.third ? WSS_SCHED_20 :
                       initSync_reg.second ? WSS_SCHED_10 : WSS_SCHED_00;
   assign panelOrBin = boardSeen_reg ? binSched : panelSchedule;
   assign seamNormal = seamSetting != WSS_SEAM_SPOT && seamSetting != WSS_SEAM_NONBEAT;

   always_comb begin
      start_next              = '0;
      start_next.sched        = start_reg.sched;
      start_next.nonBeat      = seamSetting == WSS_SEAM_NONBEAT;
      start_next.chainAllowed = !seamNormal;
      disp_next               = disp_reg;
      errLatched_next         = th_reg == TH_ERROR;
      case (mode_reg)
         WSS_MODE_INTERNAL: begin
            disp_next = panelSchedule;
            if (!sequenceBusy) begin
               if (rise1) begin
                  start_next.start = 1'b1;
                  start_next.sched = panelSchedule;
               end else if (rise2) begin
                  start_next.start = 1'b1;
                  start_next.sched = WSS_SCHED_10;
               end else if (rise3) begin
                  start_next.start = 1'b1;
                  start_next.sched = WSS_SCHED_20;
               end
            end
         end
         WSS_MODE_EXTERNAL: begin
            disp_next = extSched;
            if (!sequenceBusy && rise1) begin
               start_next.start = 1'b1;
               start_next.sched = extSched;
            end
         end
         WSS_MODE_TWOHAND: begin
            disp_next = panelOrBin;
            if (thStart) begin
               start_next.start   = 1'b1;
               start_next.twoHand = 1'b1;
               start_next.sched   = panelOrBin;
            end else if (!sequenceBusy && rise1 && th_reg == TH_IDLE) begin
               start_next.start = 1'b1;
               start_next.sched = panelOrBin;
            end
         end
         WSS_MODE_BINARY: begin
            disp_next = binSched;
            if (!sequenceBusy) begin
               if (rise1) begin
                  start_next.start = 1'b1;
                  start_next.sched = binSched;
               end else if (rise2) begin
                  start_next.start = 1'b1;
                  start_next.sched = WSS_SCHED_10;
               end else if (rise3) begin
                  start_next.start = 1'b1;
                  start_next.sched = WSS_SCHED_20;
               end
            end
         end
         default: disp_next = panelSchedule;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         start_reg      <= '0;
         disp_reg       <= WSS_SCHED_00;
         errLatched_reg <= 1'b0;
      end else begin
         start_reg      <= start_next;
         disp_reg       <= disp_next;
         errLatched_reg <= errLatched_next;
      end
   end

   // ======================================================
   // outputs
   assign scheduleSelectMode = mode_reg;
   assign startCmd           = start_reg;
   assign clearSchedules     = clear_reg;
   assign twoHandError       = errLatched_reg;
   assign retractElectrodes  = retract_reg;
   assign displaySchedule    = disp_reg;
endmodule

// ### tb/wss_checker_properties.sv
`timescale 1ns/1ns
// ========================================
// checks on the selector's ports
module wss_checker import wss_pkg::*; (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire wss_init_t  initPins,
   input wire logic [1:0] modeSetting,
   input wire logic       modeWrite,
   input wire logic [7:0] seamSetting,
   input wire logic       sequenceBusy,
   input wire logic [1:0] scheduleSelectMode,
   input wire wss_start_t startCmd,
   input wire logic       clearSchedules,
   input wire logic       twoHandError,
   input wire logic       retractElectrodes
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_mode_write: assert property (
      modeWrite && modeSetting != WSS_MODE_BINARY |=> scheduleSelectMode == $past(modeSetting))
      else $error("mode write not taken");
   a_clear_pulse: assert property (
      modeWrite && modeSetting == WSS_MODE_INTERNAL && scheduleSelectMode != WSS_MODE_INTERNAL
      |=> clearSchedules ##1 !clearSchedules) else $error("clear pulse wrong");
   a_third_sched: assert property (
      (scheduleSelectMode == WSS_MODE_INTERNAL || scheduleSelectMode == WSS_MODE_BINARY)
      && $rose(initPins.third) && !initPins.primary && !initPins.second && !sequenceBusy
      |-> ##3 startCmd.start && startCmd.sched == WSS_SCHED_20) else $error("third not 20");
   a_ext_table: assert property (
      scheduleSelectMode == WSS_MODE_EXTERNAL && startCmd.start |-> startCmd.sched ==
      ($past(initPins.third, 3) ? ($past(initPins.second, 3) ? WSS_SCHED_30 : WSS_SCHED_20)
      : ($past(initPins.second, 3) ? WSS_SCHED_10 : WSS_SCHED_00))) else $error("ext sched");
   a_sched_hold: assert property (
      !startCmd.start |-> $stable(startCmd.sched)) else $error("sched moved");
   a_seam_chain: assert property (
      seamSetting != WSS_SEAM_SPOT && seamSetting != WSS_SEAM_NONBEAT
      |=> !startCmd.chainAllowed) else $error("chain in seam");
   a_error_clears: assert property (
      initPins == 3'h0 [*6] |-> !twoHandError) else $error("error stuck");
   a_retract_mode: assert property (
      retractElectrodes |-> scheduleSelectMode == WSS_MODE_TWOHAND ##1 !retractElectrodes)
      else $error("retract wrong");
   c_start: cover property (startCmd.start);
   c_error: cover property ($rose(twoHandError));
   c_clear: cover property (clearSchedules);
endmodule

// ### tb/wss_switch_model.sv
`timescale 1ns/1ns
// ========================================
// operator switches: selects first, primary two cycles later
module wss_switch_model import wss_pkg::*; (
   input  wire logic       ref_clk,
   input  wire logic [1:0] extSel,
   input  wire logic [1:0] hands,
   input  wire logic       go,
   output wss_init_t       initPins
);
   logic [1:0] goDly = 2'h0;
   always @(negedge ref_clk) begin
      goDly <= {goDly[0], go};
   end
   assign initPins.primary = goDly[1] & go;
   assign initPins.second  = extSel[0] | hands[0];
   assign initPins.third   = extSel[1] | hands[1];
endmodule

// ### tb/test_weld_schedule_select.sv
`timescale 1ns/1ns
// ========================================
// bench
module test_weld_schedule_select import wss_pkg::*;;
   localparam int WIN = 8;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [5:0] binarySelectPins = 6'h00;
   logic       binarySelectOptionBoard = 1'b1;
   logic [1:0] modeSetting = 2'h0;
   logic       modeWrite = 1'b0;
   logic [5:0] panelSchedule = 6'h07;
   logic [7:0] seamSetting = 8'h00;
   logic       sequenceBusy = 1'b0;
   logic       squeezeActive = 1'b0;
   logic [1:0] extSel = 2'h0;
   logic [1:0] hands = 2'h0;
   logic       go = 1'b0;
   logic       seenR;
   wss_init_t  initPins;
   logic [1:0] scheduleSelectMode;
   wss_start_t startCmd;
   logic       clearSchedules;
   logic       twoHandError;
   logic       retractElectrodes;
   logic [5:0] displaySchedule;
   int         n_errors = 0;
   int         check_count = 0;
   always #5 ref_clk = ~ref_clk;
   wss_switch_model u_sw (.ref_clk, .extSel, .hands, .go, .initPins);
   wss_weld_schedule_select #(.WINDOW_CYC(WIN)) u_dut (
      .ref_clk                 (ref_clk),
      .rst                     (rst),
      .initPins                (initPins),
      .binarySelectPins        (binarySelectPins),
      .binarySelectOptionBoard (binarySelectOptionBoard),
      .modeSetting             (modeSetting),
      .modeWrite               (modeWrite),
      .panelSchedule           (panelSchedule),
      .seamSetting             (seamSetting),
      .sequenceBusy            (sequenceBusy),
      .squeezeActive           (squeezeActive),
      .scheduleSelectMode      (scheduleSelectMode),
      .startCmd                (startCmd),
      .clearSchedules          (clearSchedules),
      .twoHandError            (twoHandError),
      .retractElectrodes       (retractElectrodes),
      .displaySchedule         (displaySchedule)
   );
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic do_reset;
      rst = 1'b1;
      tick(20);
      rst = 1'b0;
      tick(2);
   endtask
   task automatic wr_mode(input logic [1:0] m, input logic [1:0] em, input logic ec);
      logic clr;
      modeSetting = m;
      modeWrite = 1'b1;
      tick(1);
      modeWrite = 1'b0;
      clr = clearSchedules;
      tick(1);
      clr = clr | clearSchedules;
      chk("mode", em, scheduleSelectMode);
      chk("clear", ec, clr);
   endtask
   task automatic fire(input logic [1:0] e, input logic [5:0] b, input logic [1:0] h,
                       input logic g, input logic want, input logic [5:0] exp);
      logic seen;
      seen = 1'b0;
      extSel = e;
      binarySelectPins = b;
      hands = h;
      go = g;
      for (int i = 0; i < 12; i++) begin
         tick(1);
         if (startCmd.start === 1'b1) begin
            seen = 1'b1;
            chk("sched", exp, startCmd.sched);
            chk("twohand", {7'h00, h == 2'h3}, startCmd.twoHand);
         end
      end
      chk("start", want, seen);
      go = 1'b0;
      hands = 2'h0;
      tick(4);
      extSel = 2'h0;
      tick(4);
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      do_reset;
      chk("mode", WSS_MODE_RESET, scheduleSelectMode);
      seamSetting = WSS_SEAM_NONBEAT;
      tick(2);
      chk("nonbeat", 1'b1, startCmd.nonBeat);
      seamSetting = 8'h01;
      tick(2);
      chk("chain", 1'b0, startCmd.chainAllowed);
      seamSetting = WSS_SEAM_SPOT;
      tick(2);
      chk("chain", 1'b1, startCmd.chainAllowed);
      chk("nonbeat", 1'b0, startCmd.nonBeat);
      fire(2'h0, 6'h00, 2'h0, 1'b1, 1'b1, 6'h07);
      fire(2'h0, 6'h00, 2'h1, 1'b0, 1'b1, WSS_SCHED_10);
      fire(2'h0, 6'h00, 2'h2, 1'b0, 1'b1, WSS_SCHED_20);
      wr_mode(WSS_MODE_EXTERNAL, WSS_MODE_EXTERNAL, 1'b0);
      for (int k = 0; k < 4; k++) fire(k[1:0], 6'h00, 2'h0, 1'b1, 1'b1, 6'(k * 10));
      fire(2'h1, 6'h00, 2'h0, 1'b0, 1'b0, 6'h00);
      wr_mode(WSS_MODE_INTERNAL, WSS_MODE_INTERNAL, 1'b1);
      wr_mode(WSS_MODE_BINARY, WSS_MODE_BINARY, 1'b0);
      fire(2'h0, 6'h05, 2'h0, 1'b1, 1'b1, 6'h05);
      fire(2'h0, 6'h37, 2'h0, 1'b1, 1'b1, WSS_SCHED_MAX);
      chk("display", WSS_SCHED_MAX, displaySchedule);
      fire(2'h0, 6'h37, 2'h1, 1'b0, 1'b1, WSS_SCHED_10);
      wr_mode(WSS_MODE_TWOHAND, WSS_MODE_TWOHAND, 1'b0);
      fire(2'h0, 6'h0C, 2'h3, 1'b0, 1'b1, 6'h0C);
      hands = 2'h3;
      tick(6);
      sequenceBusy = 1'b1;
      squeezeActive = 1'b1;
      hands = 2'h1;
      seenR = 1'b0;
      repeat (8) begin
         tick(1);
         seenR = seenR | retractElectrodes;
      end
      chk("retract", 1'b1, seenR);
      chk("error", 1'b1, twoHandError);
      hands = 2'h0;
      sequenceBusy = 1'b0;
      squeezeActive = 1'b0;
      tick(8);
      chk("error", 1'b0, twoHandError);
      hands = 2'h1;
      tick(WIN + 10);
      chk("error", 1'b1, twoHandError);
      hands = 2'h0;
      tick(8);
      chk("error", 1'b0, twoHandError);
      binarySelectOptionBoard = 1'b0;
      do_reset;
      wr_mode(WSS_MODE_BINARY, WSS_MODE_INTERNAL, 1'b0);
      report_and_stop;
   end
endmodule
bind wss_weld_schedule_select wss_checker u_chk (
   .ref_clk            (ref_clk),
   .rst                (rst),
   .initPins           (initPins),
   .modeSetting        (modeSetting),
   .modeWrite          (modeWrite),
   .seamSetting        (seamSetting),
   .sequenceBusy       (sequenceBusy),
   .scheduleSelectMode (scheduleSelectMode),
   .startCmd           (startCmd),
   .clearSchedules     (clearSchedules),
   .twoHandError       (twoHandError),
   .retractElectrodes  (retractElectrodes)
);
